// File: dpfw_core.v
// Purpose: Datapath working registers, two queues, output multiplexing and register port.
// Assumes: mclk is the high-frequency system clock; the datapath clock arrives as
//          rise and fall tick inputs synchronous to mclk.
// Notes:   The ALU lives outside; it receives the current dynamic word and the
//          accumulators and returns alu_out.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "dpfw_map.vh"
module dpfw_core (
  // Clock, reset, enable
  input  wire                  mclk,
  input  wire                  reset,
  input  wire                  ce,
  // Datapath clock ticks and sleep
  input  wire                  dp_rise,
  input  wire                  dp_fall,
  input  wire                  wakeup,
  // Register port
  input  wire [`DPFW_AW-1:0]   reg_addr,
  input  wire [7:0]            reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [7:0]            reg_rdata,
  // Routed inputs
  input  wire [2:0]            cfg_addr,
  input  wire                  dat0_load,
  input  wire                  dat1_load,
  input  wire                  queue_load_strobe0,
  input  wire                  queue_load_strobe1,
  input  wire                  shift_in,
  input  wire                  carry_in,
  input  wire [7:0]            par_in,
  // ALU link
  input  wire [7:0]            alu_out,
  output wire [7:0]            dyn_word,
  output wire [7:0]            acc0_out,
  output wire [7:0]            acc1_out,
  // Capture chain
  input  wire                  cap0_chain_in,
  input  wire                  cap1_chain_in,
  output wire                  cap0_chain_out,
  output wire                  cap1_chain_out,
  // Routed outputs
  output wire [5:0]            dp_out
);
  reg  [7:0] acc0_q, acc1_q, dat0_q, dat1_q;
  reg  [7:0] qcfg_q, qctl_q, ocomb_q;
  reg  [3:0] stat_q;
  reg  [7:0] osel_q [0:2];
  reg  [7:0] dcfg_q [0:7];
  reg  [5:0] dpout_q;
  // Edge history resets low, like an idle strobe, so no false edge follows reset.
  reg  [1:0] ld_prev_q;
  // One-stage mode reads the first stage on purpose; its source is synchronous to mclk.
  reg  [3:0] sync1_q, sync2_q;
  reg  [7:0] rdata_d;
  integer    i;

  // Picks one of the sixteen internal signals.
  function sig_pick;
    input [15:0] sigs;
    input [3:0]  sel;
    begin
      sig_pick = sigs[sel];
    end
  endfunction

  // Bus-side status: room (input) or data (output), one byte or half.
  function bus_stat;
    input       in_dir;
    input       lvl;
    input [2:0] cnt;
    begin
      if (in_dir)
        bus_stat = lvl ? (cnt <= `DPFW_QDEPTH - `DPFW_QHALF) : (cnt < `DPFW_QDEPTH);
      else
        bus_stat = lvl ? (cnt >= `DPFW_QHALF) : (cnt != 3'h0);
    end
  endfunction

  wire [1:0] dir0 = qcfg_q[`DPFW_QCFG_DIR0];
  wire [1:0] dir1 = qcfg_q[`DPFW_QCFG_DIR1];
  wire       in0  = (dir0 == `DPFW_DIR_BUS);
  wire       in1  = (dir1 == `DPFW_DIR_BUS);
  wire       sgl0 = qcfg_q[`DPFW_QCFG_SGL0];
  wire       sgl1 = qcfg_q[`DPFW_QCFG_SGL1];

  wire wr_hit = reg_wr & ce;
  wire rd_hit = reg_rd & ce;

  // The dynamic word is applied combinationally so the ALU sees it this cycle.
  assign dyn_word = dcfg_q[cfg_addr];
  wire       a0_we  = dyn_word[0];
  wire [1:0] a0_src = dyn_word[2:1];
  wire       a1_we  = dyn_word[3];
  wire [1:0] a1_src = dyn_word[5:4];

  // Software capture, locally or from the chain below.
  wire cap_en  = qctl_q[`DPFW_QCTL_CAP];
  wire chain   = qctl_q[`DPFW_QCTL_CHAIN];
  wire cap0_rq = (rd_hit & (reg_addr == `DPFW_ADDR_ACC0)) | (chain & cap0_chain_in);
  wire cap1_rq = (rd_hit & (reg_addr == `DPFW_ADDR_ACC1)) | (chain & cap1_chain_in);
  assign cap0_chain_out = chain & cap0_rq;
  assign cap1_chain_out = chain & cap1_rq;
  wire swcap0 = cap_en & ~in0 & cap0_rq;
  wire swcap1 = cap_en & ~in1 & cap1_rq;

  // Load sampling: fast mode samples every system clock, else the chosen phase.
  wire fast  = qcfg_q[`DPFW_QCFG_FAST];
  wire edgem = qcfg_q[`DPFW_QCFG_EDGE];
  wire smp0  = fast | (qctl_q[`DPFW_QCTL_POL0] ? dp_fall : dp_rise);
  wire smp1  = fast | (qctl_q[`DPFW_QCTL_POL1] ? dp_fall : dp_rise);
  // Edge mode needs the strobe low at one sample before the next capture.
  wire ld0 = smp0 & queue_load_strobe0 & ~(edgem & ld_prev_q[0]);
  wire ld1 = smp1 & queue_load_strobe1 & ~(edgem & ld_prev_q[1]);

  // Source of an output-direction queue.
  wire [7:0] src0 = (dir0 == `DPFW_DIR_ACC0) ? acc0_q :
                    (dir0 == `DPFW_DIR_ACC1) ? acc1_q : alu_out;
  wire [7:0] src1 = (dir1 == `DPFW_DIR_ACC0) ? acc0_q :
                    (dir1 == `DPFW_DIR_ACC1) ? acc1_q : alu_out;

  wire bus_w0 = wr_hit & (reg_addr == `DPFW_ADDR_QUE0);
  wire bus_w1 = wr_hit & (reg_addr == `DPFW_ADDR_QUE1);
  wire bus_r0 = rd_hit & (reg_addr == `DPFW_ADDR_QUE0);
  wire bus_r1 = rd_hit & (reg_addr == `DPFW_ADDR_QUE1);

  // Input queues feed the datapath; output queues feed the bus.
  wire push0 = in0 ? bus_w0 : (ld0 | swcap0);
  wire push1 = in1 ? bus_w1 : (ld1 | swcap1);
  wire [7:0] pdat0 = in0 ? reg_wdata : src0;
  wire [7:0] pdat1 = in1 ? reg_wdata : src1;
  wire acc0_fq = a0_we & (a0_src == `DPFW_SRC_QUE);
  wire acc1_fq = a1_we & (a1_src == `DPFW_SRC_QUE);
  wire pop0  = in0 ? (dat0_load | acc0_fq) : bus_r0;
  wire pop1  = in1 ? (dat1_load | acc1_fq) : bus_r1;

  wire [7:0] head0, head1;
  wire [2:0] cnt0, cnt1;
  wire       ovr0, ovr1, und0, und1;

  dpfw_queue u_queue0 (
    .mclk      (mclk),
    .reset     (reset),
    .ce        (ce),
    .clear     (wakeup),
    .single    (sgl0),
    .push      (push0),
    .push_data (pdat0),
    .pop       (pop0),
    .head      (head0),
    .count     (cnt0),
    .overrun   (ovr0),
    .underrun  (und0)
  );

  dpfw_queue u_queue1 (
    .mclk      (mclk),
    .reset     (reset),
    .ce        (ce),
    .clear     (wakeup),
    .single    (sgl1),
    .push      (push1),
    .push_data (pdat1),
    .pop       (pop1),
    .head      (head1),
    .count     (cnt1),
    .overrun   (ovr1),
    .underrun  (und1)
  );

  // Status, forced low in single-buffer mode.
  wire q0_bus = ~sgl0 & bus_stat(in0, qctl_q[`DPFW_QCTL_LVL0], cnt0);
  wire q1_bus = ~sgl1 & bus_stat(in1, qctl_q[`DPFW_QCTL_LVL1], cnt1);
  wire q0_blk = ~sgl0 & (in0 ? (cnt0 == 3'h0) : (cnt0 == `DPFW_QDEPTH));
  wire q1_blk = ~sgl1 & (in1 ? (cnt1 == 3'h0) : (cnt1 == `DPFW_QDEPTH));
  wire [3:0] qstat_raw = {q1_blk, q1_bus, q0_blk, q0_bus};
  wire [1:0] sync_md   = qctl_q[`DPFW_QCTL_SYNC];
  wire [3:0] qstat = (sync_md == `DPFW_SYNC_NONE) ? qstat_raw :
                     (sync_md == `DPFW_SYNC_ONE)  ? sync1_q : sync2_q;
  wire qerr0 = ovr0 | und0;
  wire qerr1 = ovr1 | und1;

  // Sixteen internal condition and status signals.
  // The parallel input is not among them: it reaches the accumulators through
  // their source select, and all sixteen selects are already spent on
  // conditions and status.
  wire [15:0] int_sig = {
    qerr1,
    qerr0,
    acc1_q < dat1_q,
    acc0_q < dat0_q,
    carry_in & (acc0_q == 8'hff),
    acc0_q[7] ^ shift_in,
    qstat,
    acc1_q == 8'hff,
    acc0_q == 8'hff,
    acc1_q == 8'h00,
    acc0_q == 8'h00,
    acc1_q == dat1_q,
    acc0_q == dat0_q
  };

  wire [5:0] dp_comb;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_out
      wire [7:0] sel_byte = osel_q[g / 2];
      assign dp_comb[g] = sig_pick(int_sig, (g % 2 == 0) ? sel_byte[3:0] : sel_byte[7:4]);
      assign dp_out[g]  = ocomb_q[g] ? dp_comb[g] : dpout_q[g];
    end
  endgenerate

  assign acc0_out = acc0_q;
  assign acc1_out = acc1_q;

  // Accumulator next values from the dynamic word.
  function [7:0] acc_next;
    input [1:0] src;
    input [7:0] alu, dat, que, par;
    begin
      case (src)
        `DPFW_SRC_ALU: acc_next = alu;
        `DPFW_SRC_DAT: acc_next = dat;
        `DPFW_SRC_QUE: acc_next = que;
        default:       acc_next = par;
      endcase
    end
  endfunction

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc0_q    <= `DPFW_RST_BYTE;
      acc1_q    <= `DPFW_RST_BYTE;
      dat0_q    <= `DPFW_RST_BYTE;
      dat1_q    <= `DPFW_RST_BYTE;
      qcfg_q    <= 8'h00;
      qctl_q    <= 8'h00;
      ocomb_q   <= 8'h00;
      stat_q    <= 4'h0;
      dpout_q   <= 6'h00;
      ld_prev_q <= 2'h0;
      sync1_q   <= 4'h0;
      sync2_q   <= 4'h0;
      reg_rdata <= 8'h00;
      for (i = 0; i < 3; i = i + 1) osel_q[i] <= 8'h00;
      for (i = 0; i < 8; i = i + 1) dcfg_q[i] <= 8'h00;
    end else if (ce) begin
      reg_rdata <= rdata_d;
      dpout_q   <= dp_comb;
      if (smp0) ld_prev_q[0] <= queue_load_strobe0;
      if (smp1) ld_prev_q[1] <= queue_load_strobe1;
      if (dp_rise) begin
        sync1_q <= qstat_raw;
        sync2_q <= sync1_q;
      end
      // Sticky errors; a new event wins over a write-one clear.
      stat_q[3:0] <= (stat_q[3:0] & ~({4{wr_hit & (reg_addr == `DPFW_ADDR_STAT)}}
                     & reg_wdata[3:0])) | {und1, ovr1, und0, ovr0};
      if (wakeup) begin
        acc0_q <= `DPFW_RST_BYTE;
        acc1_q <= `DPFW_RST_BYTE;
      end else begin
        if (wr_hit & (reg_addr == `DPFW_ADDR_ACC0)) acc0_q <= reg_wdata;
        else if (a0_we) acc0_q <= acc_next(a0_src, alu_out, dat0_q, head0, par_in);
        if (wr_hit & (reg_addr == `DPFW_ADDR_ACC1)) acc1_q <= reg_wdata;
        else if (a1_we) acc1_q <= acc_next(a1_src, alu_out, dat1_q, head1, par_in);
      end
      // Data registers ignore wakeup so they survive sleep.
      if (wr_hit & (reg_addr == `DPFW_ADDR_DAT0)) dat0_q <= reg_wdata;
      else if (dat0_load) dat0_q <= head0;
      if (wr_hit & (reg_addr == `DPFW_ADDR_DAT1)) dat1_q <= reg_wdata;
      else if (dat1_load) dat1_q <= head1;
      if (wr_hit) begin
        case (reg_addr)
          `DPFW_ADDR_QCFG:  qcfg_q    <= reg_wdata;
          `DPFW_ADDR_QCTL:  qctl_q    <= reg_wdata;
          `DPFW_ADDR_OSEL0: osel_q[0] <= reg_wdata;
          `DPFW_ADDR_OSEL1: osel_q[1] <= reg_wdata;
          `DPFW_ADDR_OSEL2: osel_q[2] <= reg_wdata;
          `DPFW_ADDR_OCOMB: ocomb_q   <= {2'h0, reg_wdata[5:0]};
          default: begin
            // Only eight dynamic words exist; the rest of the upper half is
            // left unmapped rather than aliased onto them.
            if (reg_addr[4:3] == 2'h2) dcfg_q[reg_addr[2:0]] <= reg_wdata;
          end
        endcase
      end
    end
  end

  // Read mux; a queue read returns its head, which pops in output mode.
  always @* begin
    rdata_d = 8'h00;
    if (rd_hit) begin
      case (reg_addr)
        `DPFW_ADDR_ACC0:  rdata_d = acc0_q;
        `DPFW_ADDR_ACC1:  rdata_d = acc1_q;
        `DPFW_ADDR_DAT0:  rdata_d = dat0_q;
        `DPFW_ADDR_DAT1:  rdata_d = dat1_q;
        `DPFW_ADDR_QUE0:  rdata_d = head0;
        `DPFW_ADDR_QUE1:  rdata_d = head1;
        `DPFW_ADDR_QCFG:  rdata_d = qcfg_q;
        `DPFW_ADDR_QCTL:  rdata_d = qctl_q;
        `DPFW_ADDR_STAT:  rdata_d = {qstat_raw, stat_q[3:0]};
        `DPFW_ADDR_OSEL0: rdata_d = osel_q[0];
        `DPFW_ADDR_OSEL1: rdata_d = osel_q[1];
        `DPFW_ADDR_OSEL2: rdata_d = osel_q[2];
        `DPFW_ADDR_OCOMB: rdata_d = ocomb_q;
        default: begin
          // Unmapped addresses read zero, so software can probe safely.
          if (reg_addr[4:3] == 2'h2) rdata_d = dcfg_q[reg_addr[2:0]];
        end
      endcase
    end
  end
endmodule // dpfw_core

// File: dpfw_map.vh
// Purpose: Register offsets, field positions and reset values of the datapath FIFO slice.
// Assumes: Byte-wide register port with a five-bit address.
// Notes:   Definitions only; included by the core and the queue.
`ifndef DPFW_MAP_VH
`define DPFW_MAP_VH

`define DPFW_AW          5
`define DPFW_ADDR_ACC0   5'h00
`define DPFW_ADDR_ACC1   5'h01
`define DPFW_ADDR_DAT0   5'h02
`define DPFW_ADDR_DAT1   5'h03
`define DPFW_ADDR_QUE0   5'h04
`define DPFW_ADDR_QUE1   5'h05
`define DPFW_ADDR_QCFG   5'h06
`define DPFW_ADDR_QCTL   5'h07
`define DPFW_ADDR_STAT   5'h08
`define DPFW_ADDR_OSEL0  5'h09
`define DPFW_ADDR_OSEL1  5'h0a
`define DPFW_ADDR_OSEL2  5'h0b
`define DPFW_ADDR_OCOMB  5'h0c
`define DPFW_ADDR_DCFG   5'h10

// Queue configuration register fields.
`define DPFW_QCFG_DIR0   1:0
`define DPFW_QCFG_DIR1   3:2
`define DPFW_QCFG_SGL0   4
`define DPFW_QCFG_SGL1   5
`define DPFW_QCFG_EDGE   6
`define DPFW_QCFG_FAST   7
// Queue control register fields.
`define DPFW_QCTL_CAP    0
`define DPFW_QCTL_LVL0   1
`define DPFW_QCTL_LVL1   2
`define DPFW_QCTL_POL0   3
`define DPFW_QCTL_POL1   4
`define DPFW_QCTL_CHAIN  5
`define DPFW_QCTL_SYNC   7:6

// Queue direction codes.
`define DPFW_DIR_BUS     2'h0
`define DPFW_DIR_ACC0    2'h1
`define DPFW_DIR_ACC1    2'h2
`define DPFW_DIR_ALU     2'h3
// Status synchronisation codes.
`define DPFW_SYNC_NONE   2'h0
`define DPFW_SYNC_ONE    2'h1
// Accumulator source codes in a dynamic configuration word.
`define DPFW_SRC_ALU     2'h0
`define DPFW_SRC_DAT     2'h1
`define DPFW_SRC_QUE     2'h2
`define DPFW_SRC_PAR     2'h3

`define DPFW_RST_BYTE    8'h00
`define DPFW_QDEPTH      3'h4
`define DPFW_QHALF       3'h2

`endif

// File: dpfw_queue.v
// Purpose: Four-byte queue with single-buffer option and overrun/underrun flags.
// Assumes: One clock; push and pop are one-cycle requests qualified by ce.
// Notes:   A refused push or pop leaves entries and pointers untouched.
`timescale 1ns/1ps
`include "dpfw_map.vh"
module dpfw_queue (
  // Clock and reset
  input  wire       mclk,
  input  wire       reset,
  input  wire       ce,
  input  wire       clear,
  // Mode
  input  wire       single,
  // Requests
  input  wire       push,
  input  wire [7:0] push_data,
  input  wire       pop,
  // State
  output wire [7:0] head,
  output wire [2:0] count,
  output wire       overrun,
  output wire       underrun
);
  reg [7:0] mem_q [0:3];
  reg [1:0] wptr_q;
  reg [1:0] rptr_q;
  reg [2:0] cnt_q;
  integer   i;

  wire full  = (cnt_q == `DPFW_QDEPTH);
  wire empty = (cnt_q == 3'h0);
  wire do_push = push & (single | ~full);
  wire do_pop  = pop & ~single & ~empty;

  assign head     = mem_q[rptr_q];
  assign count    = single ? 3'h0 : cnt_q;
  assign overrun  = push & ~single & full;
  assign underrun = pop & ~single & empty;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wptr_q <= 2'h0;
      rptr_q <= 2'h0;
      cnt_q  <= 3'h0;
      for (i = 0; i < 4; i = i + 1) mem_q[i] <= `DPFW_RST_BYTE;
    end else if (ce) begin
      if (clear) begin
        wptr_q <= 2'h0;
        rptr_q <= 2'h0;
        cnt_q  <= 3'h0;
        for (i = 0; i < 4; i = i + 1) mem_q[i] <= `DPFW_RST_BYTE;
      end else if (single) begin
        if (push) mem_q[rptr_q] <= push_data;
      end else begin
        if (do_push) begin
          mem_q[wptr_q] <= push_data;
          wptr_q        <= wptr_q + 2'h1;
        end
        if (do_pop) rptr_q <= rptr_q + 2'h1;
        if (do_push & ~do_pop) cnt_q <= cnt_q + 3'h1;
        else if (do_pop & ~do_push) cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule // dpfw_queue

// File: dpfw_core_assertions.sv
// Purpose: Port-level checks of the datapath working registers, capture chain and dynamic word.
// Assumes: One clock domain; register strobes are qualified by ce.
// Notes:   Bound to every dpfw_core instance at the foot of this file.
`timescale 1ns/1ps
`include "dpfw_map.vh"
module dpfw_core_checker (
  // Clock and control
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic                ce,
  input wire logic                wakeup,
  // Register port
  input wire logic [`DPFW_AW-1:0] reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  // Datapath side
  input wire logic [2:0]          cfg_addr,
  input wire logic [7:0]          dyn_word,
  input wire logic [7:0]          acc0_out,
  input wire logic [7:0]          acc1_out,
  input wire logic                cap0_chain_in,
  input wire logic                cap1_chain_in,
  input wire logic                cap0_chain_out,
  input wire logic                cap1_chain_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  rdata_idle_a: assert property (!$past(reg_rd && ce) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  acc0_read_a: assert property (reg_rd && ce && reg_addr == `DPFW_ADDR_ACC0
    |=> reg_rdata == $past(acc0_out)) else $error("acc0 read data wrong");
  acc1_read_a: assert property (reg_rd && ce && reg_addr == `DPFW_ADDR_ACC1
    |=> reg_rdata == $past(acc1_out)) else $error("acc1 read data wrong");
  acc0_write_a: assert property (reg_wr && ce && !wakeup && reg_addr == `DPFW_ADDR_ACC0
    |=> acc0_out == $past(reg_wdata)) else $error("acc0 write lost");
  acc1_write_a: assert property (reg_wr && ce && !wakeup && reg_addr == `DPFW_ADDR_ACC1
    |=> acc1_out == $past(reg_wdata)) else $error("acc1 write lost");
  wake_clear_a: assert property (wakeup && ce && !reg_wr && !dyn_word[0] && !dyn_word[3]
    |=> acc0_out == 8'h00 && acc1_out == 8'h00) else $error("accumulators kept over wakeup");
  chain0_src_a: assert property (cap0_chain_out
    |-> cap0_chain_in || (reg_rd && reg_addr == `DPFW_ADDR_ACC0)) else $error("stray chain0");
  chain1_src_a: assert property (cap1_chain_out
    |-> cap1_chain_in || (reg_rd && reg_addr == `DPFW_ADDR_ACC1)) else $error("stray chain1");
  dyn_hold_a: assert property ($stable(cfg_addr) && !$past(reg_wr) |-> $stable(dyn_word))
    else $error("dynamic word moved without cause");

  wake_c: cover property (wakeup && ce);
  chain_c: cover property (cap0_chain_out);
  acc_rd_c: cover property (reg_rd && reg_addr == `DPFW_ADDR_ACC1);
endmodule // dpfw_core_checker

bind dpfw_core dpfw_core_checker u_chk (
  .mclk(mclk), .reset(reset), .ce(ce), .wakeup(wakeup), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cfg_addr(cfg_addr), .dyn_word(dyn_word), .acc0_out(acc0_out), .acc1_out(acc1_out),
  .cap0_chain_in(cap0_chain_in), .cap1_chain_in(cap1_chain_in),
  .cap0_chain_out(cap0_chain_out), .cap1_chain_out(cap1_chain_out));

// File: dpfw_alu_model.sv
// Purpose: Behavioural ALU that answers the datapath slice combinationally.
// Assumes: The top two bits of the dynamic word pick the operation.
// Notes:   Four operations only; enough to see results written back.
`timescale 1ns/1ps
module dpfw_alu_model (
  // Operation and operands
  input  wire logic [7:0] dyn_word,
  input  wire logic [7:0] acc0,
  input  wire logic [7:0] acc1,
  // Result
  output logic      [7:0] alu_out
);
  always_comb begin
    case (dyn_word[7:6])
      2'h0: alu_out = acc0 + 8'h01;
      2'h1: alu_out = acc1 - 8'h01;
      2'h2: alu_out = acc0 + acc1;
      default: alu_out = acc0;
    endcase
  end
endmodule // dpfw_alu_model

// File: datapath_fifo_and_working_regs_tb.sv
// Purpose: Self-checking bench for the datapath working registers and queues.
// Assumes: Datapath clock ticks are driven by hand where a test needs them.
// Notes:   Shift, carry, falling tick and chain inputs stay low throughout.
`timescale 1ns/1ps
module datapath_fifo_and_working_regs_tb;
  logic       mclk = 1'b0, reset = 1'b1, ce = 1'b1, dp_rise = 1'b0, wakeup = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00, par_in = 8'h00, reg_rdata, alu_out, dyn_word, acc0, acc1;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, ld0 = 1'b0, ld1 = 1'b0, dl0 = 1'b0, dl1 = 1'b0;
  logic [2:0] cfg_addr = 3'h0;
  logic [5:0] dp_out;
  logic       ch0, ch1;
  int         miscompares = 0, n_checks = 0;

  always #20 mclk = ~mclk;

  dpfw_core DUT (.mclk(mclk), .reset(reset), .ce(ce), .dp_rise(dp_rise), .dp_fall(1'b0),
    .wakeup(wakeup), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_addr(cfg_addr), .dat0_load(dl0),
    .dat1_load(dl1), .queue_load_strobe0(ld0), .queue_load_strobe1(ld1), .shift_in(1'b0),
    .carry_in(1'b0), .par_in(par_in), .alu_out(alu_out), .dyn_word(dyn_word),
    .acc0_out(acc0), .acc1_out(acc1), .cap0_chain_in(1'b0), .cap1_chain_in(1'b0),
    .cap0_chain_out(ch0), .cap1_chain_out(ch1), .dp_out(dp_out));
  dpfw_alu_model u_alu (.dyn_word(dyn_word), .acc0(acc0), .acc1(acc1), .alu_out(alu_out));

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task rc(input logic [4:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task wake;
    @(posedge mclk) wakeup <= 1'b1;
    @(posedge mclk) wakeup <= 1'b0;
  endtask
  task t_regs;
    rc(5'h00, 8'h00, "acc0 reset");
    for (int i = 0; i < 4; i++) wr(5'(i), 8'(17 * (i + 1)));
    for (int i = 0; i < 4; i++) rc(5'(i), 8'(17 * (i + 1)), "working reg");
    wr(5'h1f, 8'hff);
    rc(5'h1f, 8'h00, "unmapped");
    $display("t_regs finished");
  endtask
  task t_wake;
    wr(5'h04, 8'h5a);
    wake();
    rc(5'h00, 8'h00, "acc0 wake");
    rc(5'h01, 8'h00, "acc1 wake");
    rc(5'h02, 8'h33, "dat0 kept");
    rc(5'h08, 8'hf0, "queues empty");
    $display("t_wake finished");
  endtask
  task t_queue;
    for (int i = 0; i < 5; i++) wr(5'h04, 8'(8'ha0 + i));
    rc(5'h08, 8'hc1, "full and overrun");
    wr(5'h08, 8'h01);
    @(posedge mclk) dl0 <= 1'b1;
    @(posedge mclk) dl0 <= 1'b0;
    rc(5'h02, 8'ha0, "dat0 from queue");
    wr(5'h07, 8'h02);
    rc(5'h08, 8'hc0, "three held level");
    @(posedge mclk) dl0 <= 1'b1;
    @(posedge mclk) dl0 <= 1'b0;
    rc(5'h08, 8'hd0, "two free level");
    wr(5'h05, 8'h77);
    @(posedge mclk) dl1 <= 1'b1;
    @(posedge mclk) dl1 <= 1'b0;
    rc(5'h03, 8'h77, "dat1 from queue");
    $display("t_queue finished");
  endtask
  task t_cap;
    wake();
    wr(5'h06, 8'h09);
    wr(5'h07, 8'h21);
    wr(5'h00, 8'h3c);
    wr(5'h01, 8'hc3);
    @(posedge mclk);
    reg_addr <= 5'h00;
    reg_rd <= 1'b1;
    #1 chk("chain0 out", 8'h01, {7'h00, ch0});
    @(posedge mclk) reg_rd <= 1'b0;
    rc(5'h04, 8'h3c, "queue0 capture");
    @(posedge mclk);
    reg_addr <= 5'h01;
    reg_rd <= 1'b1;
    #1 chk("chain1 out", 8'h01, {7'h00, ch1});
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk("acc1 read", 8'hc3, reg_rdata);
    rc(5'h05, 8'hc3, "queue1 capture");
    @(posedge mclk);
    reg_addr <= 5'h05;
    reg_rd <= 1'b1;
    @(posedge mclk) reg_rd <= 1'b0;
    rc(5'h08, 8'h08, "underrun");
    wr(5'h08, 8'h0f);
    $display("t_cap finished");
  endtask
  task t_load;
    wake();
    wr(5'h00, 8'h20);
    wr(5'h01, 8'h40);
    wr(5'h07, 8'h00);
    wr(5'h06, 8'hcb);
    @(posedge mclk) {ld0, ld1} <= 2'b11;
    repeat (3) @(posedge mclk);
    {ld0, ld1} <= 2'b00;
    @(posedge mclk) {ld0, ld1} <= 2'b11;
    @(posedge mclk) {ld0, ld1} <= 2'b00;
    for (int i = 0; i < 2; i++) rc(5'h04, 8'h21, "queue0 alu edge");
    for (int i = 0; i < 2; i++) rc(5'h05, 8'h40, "queue1 edge");
    wr(5'h06, 8'h0b);
    @(posedge mclk) ld0 <= 1'b1;
    repeat (2) begin
      @(posedge mclk) dp_rise <= 1'b1;
      @(posedge mclk) dp_rise <= 1'b0;
    end
    @(posedge mclk) ld0 <= 1'b0;
    for (int i = 0; i < 2; i++) rc(5'h04, 8'h21, "queue0 level");
    rc(5'h08, 8'h00, "two pushes only");
    $display("t_load finished");
  endtask
  task t_single;
    wake();
    wr(5'h06, 8'h10);
    wr(5'h04, 8'h61);
    wr(5'h04, 8'h62);
    for (int i = 0; i < 2; i++) rc(5'h04, 8'h62, "single buffer");
    rc(5'h08, 8'hc0, "single no status");
    $display("t_single finished");
  endtask
  task t_dyn;
    wake();
    wr(5'h02, 8'h42);
    wr(5'h13, 8'h03);
    wr(5'h12, 8'h01);
    wr(5'h14, 8'h07);
    @(posedge mclk) cfg_addr <= 3'h3;
    @(posedge mclk) cfg_addr <= 3'h2;
    @(posedge mclk) cfg_addr <= 3'h0;
    rc(5'h00, 8'h43, "acc0 dyn then alu");
    @(posedge mclk);
    par_in <= 8'h9e;
    cfg_addr <= 3'h4;
    @(posedge mclk) cfg_addr <= 3'h0;
    rc(5'h00, 8'h9e, "acc0 parallel");
    @(posedge mclk);
    ce <= 1'b0;
    cfg_addr <= 3'h3;
    @(posedge mclk);
    ce <= 1'b1;
    cfg_addr <= 3'h0;
    rc(5'h00, 8'h9e, "acc0 frozen");
    $display("t_dyn finished");
  endtask
  task t_out;
    wake();
    wr(5'h09, 8'h02);
    wr(5'h00, 8'h05);
    #1 chk("out0 registered", 8'h01, {7'h00, dp_out[0]});
    @(posedge mclk);
    #1 chk("out0 follows", 8'h00, {7'h00, dp_out[0]});
    wr(5'h0c, 8'h01);
    wr(5'h00, 8'h00);
    #1 chk("out0 combinational", 8'h01, {7'h00, dp_out[0]});
    wr(5'h02, 8'h00);
    #1 chk("outs before", 8'h01, {2'h0, dp_out});
    @(posedge mclk);
    #1 chk("outs registered", 8'h3f, {2'h0, dp_out});
    $display("t_out finished");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_wake();
    t_queue();
    t_cap();
    t_load();
    t_single();
    t_dyn();
    t_out();
    complete_run();
  end
  // The tests need well under 1000 cycles; this cuts a hang short.
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule // datapath_fifo_and_working_regs_tb
